// ### rtl/msue_engine.v
// Purpose: M-sequence receive, checksum and reply engine on the CQ line
// Assumes: cq_rx_i is the line level after the analog threshold stage
// Notes:   host reaches the buffer and flags through plain ports
`timescale 1ns/10ps
`include "msue_map.vh"
module msue_engine (
    input  wire       clk_i,
    input  wire       reset_n_i,
    input  wire       cq_rx_i,
    output reg        cq_o,
    output reg        cq_oe_o,
    output reg        cq_hs_en_o,
    output reg        cq_ls_en_o,
    output reg        thr_ref_half_o,
    input  wire       baud_select_i,
    input  wire       threshold_reference_select_i,
    input  wire [3:0] type2_read_octets_i,
    input  wire [1:0] type1_ondemand_width_i,
    input  wire [1:0] type2_ondemand_width_i,
    input  wire       send_trigger_i,
    input  wire       end_trigger_i,
    input  wire [3:0] octet_count_i,
    input  wire       buf_we_i,
    input  wire [3:0] buf_addr_i,
    input  wire [7:0] buf_wdata_i,
    output reg  [7:0] buf_rdata_o,
    output reg  [3:0] octet_count_o,
    output reg        message_ready_flag_o,
    output reg        checksum_error_flag_o,
    output reg        message_event_o,
    output wire       transmit_state_o
);
    ////////////////////////////////////////////////////////////////////////
    // Timing constants
    localparam integer BIT_HI_N = `MSUE_CLK_HZ / `MSUE_BAUD_COM3;
    localparam integer BIT_LO_N = `MSUE_CLK_HZ / `MSUE_BAUD_COM2;
    localparam integer FLT_HI_N = (`MSUE_CLK_HZ + `MSUE_BAUD_COM3 *
                                   `MSUE_SUB_DIV - 1) /
                                  (`MSUE_BAUD_COM3 * `MSUE_SUB_DIV);
    localparam integer FLT_LO_N = (`MSUE_CLK_HZ + `MSUE_BAUD_COM2 *
                                   `MSUE_SUB_DIV - 1) /
                                  (`MSUE_BAUD_COM2 * `MSUE_SUB_DIV);
    localparam integer SUB_HI_N = BIT_HI_N / `MSUE_SUB_DIV;
    localparam integer SUB_LO_N = BIT_LO_N / `MSUE_SUB_DIV;
    localparam integer GAP_HI_N = BIT_HI_N * `MSUE_GAP_BITS;
    localparam integer GAP_LO_N = BIT_LO_N * `MSUE_GAP_BITS;
    localparam [9:0]   BIT_HI   = BIT_HI_N[9:0];
    localparam [9:0]   BIT_LO   = BIT_LO_N[9:0];
    localparam [5:0]   FLT_HI   = FLT_HI_N[5:0];
    localparam [5:0]   FLT_LO   = FLT_LO_N[5:0];
    localparam [5:0]   SUB_HI   = SUB_HI_N[5:0];
    localparam [5:0]   SUB_LO   = SUB_LO_N[5:0];
    localparam [11:0]  GAP_HI   = GAP_HI_N[11:0];
    localparam [11:0]  GAP_LO   = GAP_LO_N[11:0];
    localparam integer BUF_N    = `MSUE_BUF_DEPTH;
    localparam [3:0]   BUF_MAX  = BUF_N[3:0];

    // Engine states
    localparam [2:0] S_LISTEN = 3'h0;
    localparam [2:0] S_FRAME  = 3'h1;
    localparam [2:0] S_GAP    = 3'h2;
    localparam [2:0] S_WAIT   = 3'h3;
    localparam [2:0] S_TX     = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Functions
    // Fold the 8-bit XOR into the 6-bit checksum
    function [5:0] compact;
        input [7:0] d;
        begin
            compact = {d[7] ^ d[5] ^ d[3] ^ d[1],
                       d[6] ^ d[4] ^ d[2] ^ d[0],
                       d[7] ^ d[6], d[5] ^ d[4],
                       d[3] ^ d[2], d[1] ^ d[0]};
        end
    endfunction

    // On-demand octets for a width code
    function [3:0] od_len;
        input [1:0] w;
        begin
            case (w)
                2'h1:    od_len = 4'h2;
                2'h2:    od_len = 4'h8;
                default: od_len = 4'h1;
            endcase
        end
    endfunction

    // Expected message length from MC and CKT octets
    function [4:0] exp_len;
        input [7:0] mc;
        input [7:0] ckt;
        reg   [4:0] n;
        begin
            n = 5'h2;
            case (ckt[7:6])
                `MSUE_TYPE0: n = mc[`MSUE_RW_BIT] ? 5'h2 : 5'h3;
                `MSUE_TYPE1: begin
                    if (type1_ondemand_width_i == 2'h0) begin
                        n = {1'b0, type2_read_octets_i} +
                            (mc[`MSUE_RW_BIT] ? 5'h0 :
                             {1'b0, od_len(type2_ondemand_width_i)});
                    end else begin
                        n = mc[`MSUE_RW_BIT] ? 5'h2 :
                            5'h2 + {1'b0, od_len(type1_ondemand_width_i)};
                    end
                end
                `MSUE_TYPE2: n = {1'b0, type2_read_octets_i} +
                    (mc[`MSUE_RW_BIT] ? 5'h0 :
                     {1'b0, od_len(type2_ondemand_width_i)});
                default: n = 5'h2;
            endcase
            exp_len = (n > {1'b0, BUF_MAX}) ? {1'b0, BUF_MAX} : n;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [7:0]  mem [0:`MSUE_BUF_DEPTH-1];
    reg         rx_s1;
    reg         rx_s2;
    reg         rx_f;
    reg  [5:0]  flt_cnt;
    reg  [5:0]  sub_cnt;
    reg  [2:0]  state;
    reg  [9:0]  rx_cnt;
    reg  [3:0]  rx_idx;
    reg  [8:0]  rx_sh;
    reg  [11:0] gap_cnt;
    reg  [7:0]  rx_xor;
    reg  [7:0]  mc_oct;
    reg  [5:0]  rx_ck;
    reg  [4:0]  rx_exp;
    reg         rx_perr;
    reg  [3:0]  tx_n;
    reg  [3:0]  ld_idx;
    reg  [7:0]  ld_xor;
    reg         ser_busy;
    reg  [10:0] ser_sh;
    reg  [3:0]  ser_bit;
    reg  [9:0]  ser_cnt;
    wire [9:0]  bit_len;
    wire [5:0]  flt_len;
    wire [5:0]  sub_len;
    wire [11:0] gap_len;
    wire        sub_tick;
    wire        rx_bit;
    wire        start_seen;
    wire        ld_more;
    wire        ld_last;
    wire [7:0]  ld_raw;
    wire [7:0]  ld_data;
    wire        f_in_ready;
    wire        f_out_valid;
    wire [7:0]  f_out_data;
    wire        ser_pop;
    wire        tx_done;
    wire [7:0]  oct;
    wire [7:0]  oct_ck;
    wire [7:0]  acc_new;
    wire        oct_done;
    wire        last_oct;
    wire [4:0]  cur_exp;
    wire        trig;

    ////////////////////////////////////////////////////////////////////////
    // Rate selection
    assign bit_len = baud_select_i ? BIT_HI : BIT_LO;
    assign flt_len = baud_select_i ? FLT_HI : FLT_LO;
    assign sub_len = baud_select_i ? SUB_HI : SUB_LO;
    assign gap_len = baud_select_i ? GAP_HI : GAP_LO;
    assign sub_tick = (sub_cnt == sub_len - 6'h1);
    assign transmit_state_o = (state == S_WAIT) | (state == S_TX);
    assign trig = send_trigger_i | end_trigger_i;

    // Line sync, glitch filter and sixteenth-bit tick
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_s1   <= 1'b0;
            rx_s2   <= 1'b0;
            rx_f    <= 1'b0;
            flt_cnt <= 6'h0;
            sub_cnt <= 6'h0;
            thr_ref_half_o <= 1'b0;
        end else begin
            rx_s1 <= cq_rx_i;
            rx_s2 <= rx_s1;
            thr_ref_half_o <= threshold_reference_select_i;
            if (rx_s2 == rx_f) begin
                flt_cnt <= 6'h0;
            end else if (flt_cnt + 6'h1 >= flt_len) begin
                rx_f    <= rx_s2;
                flt_cnt <= 6'h0;
            end else begin
                flt_cnt <= flt_cnt + 6'h1;
            end
            sub_cnt <= sub_tick ? 6'h0 : sub_cnt + 6'h1;
        end
    end

    // Logical bit is the inverted line; start bit is the line going high
    assign rx_bit     = ~rx_f;
    assign start_seen = ~rx_bit;

    ////////////////////////////////////////////////////////////////////////
    // Receive octet assembly and checksum
    assign oct      = rx_sh[7:0];
    // The type octet joins the sum with its checksum field cleared
    assign oct_ck   = (octet_count_o == 4'h1) ?
                      (oct & `MSUE_CKT_TYPE_M) : oct;
    assign acc_new  = rx_xor ^ oct_ck;
    assign oct_done = (state == S_FRAME) && (rx_cnt == 10'h0) &&
                      (rx_idx == `MSUE_STOP_IDX);
    // Length is known as the type octet lands, so use it in that cycle
    assign cur_exp  = (octet_count_o == 4'h1) ?
                      exp_len(mc_oct, oct) : rx_exp;
    assign last_oct = (octet_count_o != 4'h0) &&
                      (({1'b0, octet_count_o} + 5'h1 >= cur_exp) ||
                       (octet_count_o + 4'h1 == BUF_MAX));

    // Main sequence: listen, frames, gaps, wait for host, transmit
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state   <= S_LISTEN;
            rx_cnt  <= 10'h0;
            rx_idx  <= 4'h0;
            rx_sh   <= 9'h0;
            gap_cnt <= 12'h0;
            rx_xor  <= `MSUE_CK_SEED;
            mc_oct  <= 8'h0;
            rx_ck   <= 6'h0;
            rx_exp  <= {1'b0, BUF_MAX};
            rx_perr <= 1'b0;
            tx_n    <= 4'h0;
            octet_count_o         <= 4'h0;
            message_ready_flag_o  <= 1'b0;
            checksum_error_flag_o <= 1'b0;
            message_event_o       <= 1'b0;
        end else begin
            message_event_o <= 1'b0;
            case (state)
                S_LISTEN, S_GAP: begin
                    gap_cnt <= gap_cnt + 12'h1;
                    if (start_seen) begin
                        state  <= S_FRAME;
                        rx_cnt <= {1'b0, bit_len[9:1]};
                        rx_idx <= 4'h0;
                        if (state == S_LISTEN) begin
                            octet_count_o <= 4'h0;
                            rx_xor  <= `MSUE_CK_SEED;
                            rx_perr <= 1'b0;
                            rx_exp  <= {1'b0, BUF_MAX};
                        end
                    end else if (state == S_GAP && gap_cnt > gap_len) begin
                        message_ready_flag_o  <= 1'b1;
                        checksum_error_flag_o <= 1'b1;
                        message_event_o       <= 1'b1;
                        state <= S_WAIT;
                    end
                end
                S_FRAME: begin
                    if (rx_cnt != 10'h0) begin
                        rx_cnt <= rx_cnt - 10'h1;
                    end else if (rx_idx == 4'h0 && rx_bit) begin
                        state <= (octet_count_o == 4'h0) ? S_LISTEN : S_GAP;
                    end else if (rx_idx != `MSUE_STOP_IDX) begin
                        if (rx_idx != 4'h0) begin
                            rx_sh <= {rx_bit, rx_sh[8:1]};
                        end
                        rx_idx <= rx_idx + 4'h1;
                        rx_cnt <= bit_len - 10'h1;
                    end else begin
                        mem[octet_count_o] <= oct;
                        octet_count_o <= octet_count_o + 4'h1;
                        rx_xor  <= acc_new;
                        gap_cnt <= 12'h0;
                        if ((^rx_sh) | ~rx_bit) begin
                            rx_perr <= 1'b1;
                        end
                        if (rx_idx == `MSUE_STOP_IDX && octet_count_o == 4'h0)
                        begin
                            mc_oct <= oct;
                        end
                        if (octet_count_o == 4'h1) begin
                            rx_ck  <= oct[5:0];
                            rx_exp <= exp_len(mc_oct, oct);
                        end
                        if (last_oct) begin
                            message_ready_flag_o <= 1'b1;
                            checksum_error_flag_o <=
                                (compact(acc_new) !=
                                 ((octet_count_o == 4'h1) ? oct[5:0] : rx_ck))
                                | rx_perr | (^rx_sh) | ~rx_bit;
                            message_event_o <= 1'b1;
                            state <= S_WAIT;
                        end else begin
                            state <= S_GAP;
                        end
                    end
                end
                S_WAIT: begin
                    if (send_trigger_i) begin
                        tx_n  <= octet_count_i;
                        state <= S_TX;
                    end else if (end_trigger_i) begin
                        state <= S_LISTEN;
                    end
                    if (trig) begin
                        message_ready_flag_o  <= 1'b0;
                        checksum_error_flag_o <= 1'b0;
                    end
                    if (buf_we_i) begin
                        mem[buf_addr_i] <= buf_wdata_i;
                    end
                end
                S_TX: begin
                    if (tx_done) begin
                        state <= S_LISTEN;
                    end
                end
                default: state <= S_LISTEN;
            endcase
        end
    end

    // Host read port of the buffer
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            buf_rdata_o <= 8'h0;
        end else begin
            buf_rdata_o <= (buf_addr_i < BUF_MAX) ? mem[buf_addr_i] : 8'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply loader: buffer into FIFO with running checksum
    assign ld_more = (state == S_TX) && (ld_idx < tx_n);
    assign ld_last = (ld_idx + 4'h1 == tx_n);
    assign ld_raw  = mem[ld_idx];
    assign ld_data = ld_last ?
                     {ld_raw[7:6], compact(ld_xor ^ ld_raw)} :
                     ld_raw;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ld_idx <= 4'h0;
            ld_xor <= `MSUE_CK_SEED;
        end else if (state != S_TX) begin
            ld_idx <= 4'h0;
            ld_xor <= `MSUE_CK_SEED;
        end else if (ld_more && f_in_ready) begin
            ld_idx <= ld_idx + 4'h1;
            ld_xor <= ld_xor ^ ld_raw;
        end
    end

    msue_fifo #(
        .WIDTH (8),
        .DEPTH (`MSUE_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (ld_more),
        .in_ready_o  (f_in_ready),
        .in_data_i   (ld_data),
        .out_valid_o (f_out_valid),
        .out_ready_i (ser_pop),
        .out_data_o  (f_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serializer, started on the sixteenth-bit tick
    assign ser_pop = ~ser_busy & f_out_valid & sub_tick;
    assign tx_done = ~ser_busy & ~f_out_valid & ~ld_more;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ser_busy <= 1'b0;
            ser_sh   <= 11'h7ff;
            ser_bit  <= 4'h0;
            ser_cnt  <= 10'h0;
        end else if (ser_pop) begin
            ser_busy <= 1'b1;
            ser_sh   <= {1'b1, ^f_out_data, f_out_data, 1'b0};
            ser_bit  <= 4'h0;
            ser_cnt  <= bit_len - 10'h1;
        end else if (ser_busy) begin
            if (ser_cnt != 10'h0) begin
                ser_cnt <= ser_cnt - 10'h1;
            end else begin
                ser_sh  <= {1'b1, ser_sh[10:1]};
                ser_cnt <= bit_len - 10'h1;
                ser_bit <= ser_bit + 4'h1;
                if (ser_bit == `MSUE_STOP_IDX) begin
                    ser_busy <= 1'b0;
                end
            end
        end
    end

    // Line drive: both switches on while replying
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cq_o       <= 1'b0;
            cq_oe_o    <= 1'b0;
            cq_hs_en_o <= 1'b0;
            cq_ls_en_o <= 1'b0;
        end else begin
            cq_o       <= ser_busy ? ~ser_sh[0] : 1'b0;
            cq_oe_o    <= (state == S_TX);
            cq_hs_en_o <= (state == S_TX);
            cq_ls_en_o <= (state == S_TX);
        end
    end
endmodule // msue_engine

// ### rtl/msue_map.vh
// Purpose: constants of the M-sequence UART message engine
// Assumes: 20 MHz system clock
// Notes:   definitions only, included by msue_engine.v
`ifndef MSUE_MAP_VH
`define MSUE_MAP_VH

`define MSUE_CLK_HZ      20000000
`define MSUE_BAUD_COM3   230400
`define MSUE_BAUD_COM2   38400
`define MSUE_SUB_DIV     16
`define MSUE_GAP_BITS    4
`define MSUE_CK_SEED     8'h52
`define MSUE_BUF_DEPTH   15
`define MSUE_FIFO_DEPTH  8
`define MSUE_CKT_TYPE_M  8'hc0
`define MSUE_TYPE0       2'h0
`define MSUE_TYPE1       2'h1
`define MSUE_TYPE2       2'h2
`define MSUE_RW_BIT      7
`define MSUE_STOP_IDX    4'ha
`define MSUE_PAR_IDX     4'h9

`endif

// ### rtl/msue_fifo.v
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes:   in_ready_o low when full, out_valid_o low when empty
`timescale 1ns/10ps
module msue_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,
    input  wire             reset_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      fill;
    wire            push;
    wire            pop;

    // Honest full and empty from the fill level
    assign in_ready_o  = (fill != DEPTH[AW:0]);
    assign out_valid_o = (fill != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Storage is written without reset
    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill level
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                fill <= fill + 1'b1;
            end else if (pop & ~push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule // msue_fifo

// ### testbench/msue_engine_monitor.sv
// Purpose: concurrent checks on the message engine ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   attached to every engine instance by bind
`timescale 1ns/10ps
module msue_engine_monitor (
    input wire       clk_i,
    input wire       reset_n_i,
    input wire       cq_o,
    input wire       cq_oe_o,
    input wire       cq_hs_en_o,
    input wire       cq_ls_en_o,
    input wire       send_trigger_i,
    input wire       end_trigger_i,
    input wire [3:0] octet_count_i,
    input wire       message_ready_flag_o,
    input wire       checksum_error_flag_o,
    input wire       message_event_o,
    input wire       transmit_state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Host triggers count only while the engine waits and is not driving
    wire wt = transmit_state_o && !cq_oe_o;
    AST_RDY: assert property ($rose(message_ready_flag_o) |->
        message_event_o && transmit_state_o) else $error("Ready without event");
    AST_EVT: assert property (message_event_o |->
        message_ready_flag_o ##1 !message_event_o) else $error("Event too long");
    AST_CLR: assert property ((send_trigger_i || end_trigger_i) && wt |=>
        !message_ready_flag_o && !checksum_error_flag_o) else $error("No clear");
    AST_END: assert property (end_trigger_i && wt |=>
        !transmit_state_o && !cq_oe_o) else $error("End did not listen");
    AST_SND: assert property (send_trigger_i && wt && octet_count_i != 4'h0
        |-> ##2 cq_oe_o) else $error("Send did not drive");
    AST_START: assert property ($rose(cq_oe_o) |-> ##[0:40] cq_o)
        else $error("Start bit late");
    AST_PP: assert property (cq_oe_o |-> cq_hs_en_o && cq_ls_en_o)
        else $error("Switches not push-pull");
    AST_IDLE: assert property (!cq_oe_o |-> !cq_o)
        else $error("Line not idle low");
endmodule // msue_engine_monitor
bind msue_engine msue_engine_monitor u_mon (.*);

// ### testbench/msue_master.sv
// Purpose: line master that sends frames and reads the reply
// Assumes: bit_clk holds clocks per bit of the chosen rate
// Notes:   line rests low whenever nobody drives it
`timescale 1ns/10ps
module msue_master (
    input  wire clk_i,
    input  wire dev_d_i,
    input  wire dev_oe_i,
    output wire line_o
);
    reg     drv = 1'b0;
    reg     late = 1'b0;
    integer bit_clk = 86;
    // Device drive wins while enabled, else master level
    assign line_o = dev_oe_i ? dev_d_i : drv;
    // Hold a line level for n clocks
    task hold(input v, input integer n);
        begin
            drv <= v;
            repeat (n) @(posedge clk_i);
        end
    endtask
    // One frame: inverted levels, LSB first, even parity unless spoiled
    task send(input [7:0] d, input bad);
        integer i;
        begin
            hold(1'b1, bit_clk);
            for (i = 0; i < 8; i = i + 1) hold(~d[i], bit_clk);
            hold(~(^d ^ bad), bit_clk);
            hold(1'b0, bit_clk);
        end
    endtask
    // Sample one reply frame at bit centres, logical values
    task recv(output [10:0] f);
        integer i;
        begin
            f = 11'h000;
            i = 0;
            while (!line_o && i < 2000) begin
                @(posedge clk_i);
                i = i + 1;
            end
            if (i == 2000) late = 1'b1; // Reply never started
            repeat (bit_clk / 2) @(posedge clk_i);
            for (i = 0; i < 11; i = i + 1) begin
                f[i] = ~line_o;
                if (i < 10) repeat (bit_clk) @(posedge clk_i);
            end
        end
    endtask
endmodule // msue_master

// ### testbench/tb_msue_engine.sv
// Purpose: self-checking bench of the M-sequence message engine
// Assumes: 230.4k bit is 86 clocks, 38.4k bit is 520 clocks
// Notes:   master model drives the line, bench plays the host
`timescale 1ns/10ps
module tb_msue_engine;
    reg         clk_i = 1'b0;
    reg         reset_n_i = 1'b0;
    reg         baud_select_i = 1'b1;
    reg         threshold_reference_select_i = 1'b0;
    reg         send_trigger_i = 1'b0;
    reg         end_trigger_i = 1'b0;
    reg  [3:0]  octet_count_i = 4'h0;
    reg         buf_we_i = 1'b0;
    reg  [3:0]  buf_addr_i = 4'h0;
    reg  [7:0]  buf_wdata_i = 8'h00;
    reg  [3:0]  type2_read_octets_i = 4'h4;
    reg  [1:0]  type1_ondemand_width_i = 2'h1;
    reg  [1:0]  type2_ondemand_width_i = 2'h0;
    reg  [10:0] f;
    integer     errors;
    integer     num_checks;
    wire        cq_rx, cq_o, cq_oe_o, cq_hs_en_o, cq_ls_en_o;
    wire        thr_ref_half_o, message_event_o, transmit_state_o;
    wire        message_ready_flag_o, checksum_error_flag_o;
    wire [7:0]  buf_rdata_o;
    wire [3:0]  octet_count_o;
    // Engine with length settings held fixed
    msue_engine dut (.cq_rx_i(cq_rx), .*);
    msue_master m (.clk_i(clk_i), .dev_d_i(cq_o), .dev_oe_i(cq_oe_o),
        .line_o(cq_rx));
    initial forever #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("wrong value at %0t: %h vs %h", $time, got, exp);
            end
        end
    endtask
    // Fold an 8-bit XOR sum to six bits
    function [7:0] cks(input [7:0] d);
        cks = {2'h0, d[7]^d[5]^d[3]^d[1], d[6]^d[4]^d[2]^d[0],
               d[7]^d[6], d[5]^d[4], d[3]^d[2], d[1]^d[0]};
    endfunction
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Master message of MC and, unless ckt is 8'hff, CKT octet, then wait for the ready flag
    task msg(input [7:0] mc, input [7:0] ckt, input bad, input [7:0] e);
        integer n;
        begin
            m.send(mc, 1'b0);
            if (ckt != 8'hff) m.send(ckt, bad);
            for (n = 0; n < 9000 && message_ready_flag_o !== 1'b1; n = n + 1)
                @(posedge clk_i);
            if (n == 9000) begin
                errors = errors + 1;
                give_verdict;
            end
            #1;
            chk(transmit_state_o, 8'h01);
            chk(checksum_error_flag_o, e);
        end
    endtask
    // Host trigger: send when s is set, else end
    task trig(input s, input [3:0] n);
        begin
            @(posedge clk_i);
            send_trigger_i <= s;
            end_trigger_i <= ~s;
            octet_count_i <= n;
            @(posedge clk_i);
            send_trigger_i <= 1'b0;
            end_trigger_i <= 1'b0;
            @(posedge clk_i);
            #1;
            chk({message_ready_flag_o, checksum_error_flag_o}, 8'h00);
            chk(transmit_state_o, {7'h0, s});
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            buf_we_i <= 1'b1;
            buf_addr_i <= a;
            buf_wdata_i <= d;
            @(posedge clk_i);
            buf_we_i <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        errors = 0;
        num_checks = 0;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        threshold_reference_select_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        m.hold(1'b1, 3);
        m.hold(1'b0, 400);
        chk({message_ready_flag_o, octet_count_o}, 8'h00);
        chk(thr_ref_half_o, 8'h01);
        msg(8'h80, cks(8'h52 ^ 8'h80), 1'b0, 8'h00);
        chk(octet_count_o, 8'h02);
        repeat (2) @(posedge clk_i);
        #1;
        chk(buf_rdata_o, 8'h80);
        trig(1'b0, 4'h0);
        $display("test good message done");
        @(posedge clk_i);
        baud_select_i <= 1'b0;
        m.bit_clk = 520;
        msg(8'h80, cks(8'h52 ^ 8'h80) ^ 8'h01, 1'b0, 8'h01);
        trig(1'b0, 4'h0);
        @(posedge clk_i);
        baud_select_i <= 1'b1;
        m.bit_clk = 86;
        msg(8'h80, cks(8'h52 ^ 8'h80), 1'b1, 8'h01);
        trig(1'b0, 4'h0);
        msg(8'h80, 8'hff, 1'b0, 8'h01);
        trig(1'b0, 4'h0);
        // Type 2 read: two more octets follow the type octet
        m.send(8'h80, 1'b0);
        m.send(8'h80 | cks(8'h52 ^ 8'h80 ^ 8'h80 ^ 8'h11 ^ 8'h22), 1'b0);
        m.send(8'h11, 1'b0);
        msg(8'h22, 8'hff, 1'b0, 8'h00);
        chk(octet_count_o, 8'h04);
        trig(1'b0, 4'h0);
        $display("test error cases done");
        msg(8'h80, cks(8'h52 ^ 8'h80), 1'b0, 8'h00);
        wr(4'h0, 8'ha5);
        wr(4'h1, 8'h80);
        trig(1'b1, 4'h2);
        m.recv(f);
        chk(f[8:1], 8'ha5);
        chk({f[10:9], f[0]}, {5'h0, 1'b1, ^8'ha5, 1'b0});
        m.recv(f);
        chk(f[8:1], 8'h80 | cks(8'h52 ^ 8'ha5 ^ 8'h80));
        if (m.late) begin
            errors = errors + 1;
            give_verdict;
        end
        repeat (86) @(posedge clk_i);
        #1;
        chk(cq_oe_o, 8'h00);
        $display("test reply done");
        give_verdict;
    end
endmodule // tb_msue_engine
